/* File: design/usbebc_top.sv */
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/100ps
// Overview of operation
// RQ1 - Words 0x0-0xff hold setup and control words, 0x100-0xfff data buffers.
// RQ2 - Endpoint zero has no config word; its buffers start at 0x100.
// RQ3 - Endpoint zero interrupt enables come from main control register.
// RQ4 - Config bit 31 enables endpoint, bit 30 selects double buffering.
// RQ5 - Bit 29 interrupts every buffer, bit 28 every two when double buffered.
// RQ6 - Bits 27:26 give type: control, isochronous, bulk, interrupt.
// RQ7 - Host interrupt endpoints poll every bits 25:18 plus one milliseconds.
// RQ8 - Bit 17 enables stall interrupt, bit 16 enables NAK interrupt.
// RQ9 - Bits 15:6 give 64-byte aligned buffer base.
// RQ10 - Single buffered endpoints use only low half of state word.
// RQ11 - Hidden buffer selector starts at 0 and alternates per buffer.
// RQ12 - State bit 12 forces selector to 0; cleared at transfer end.
// RQ13 - Full flags 31/15: set on OUT fill, cleared on IN send.
// RQ14 - Available flags 26/10 cleared once buffer is used.
// RQ15 - Bits 30/14 mark last buffer of a transfer.
// RQ16 - Bits 29/13 hold data toggle of each buffer.
// RQ17 - Isochronous second buffer spacing 128, 256, 512 or 1024 bytes.
// RQ18 - Bits 25:16 and 9:0 hold buffer byte counts.
// RQ19 - Bit 11 requests stall in device mode, reports stall in host.
// RQ20 - Host interrupt/iso buffers marked full even on failure, error flagged.
// RQ21 - Software writes available and stall after other state fields.
// RQ22 - Setup packets always accepted, stored at 0x0, then acknowledged; the code takes one only with SETUP_OK high and no setup pending.
// RQ23 - Endpoint zero stalls need stall flag and gate; setup clears gates.
// RQ24 - Setup sets received flag; interrupt only when enabled.
module usbebc_top (
  input  wire logic                 CORE_CLK,
  input  wire logic                 RST,
  input  wire logic                 PSEL,
  input  wire logic                 PENABLE,
  input  wire logic                 PWRITE,
  input  wire logic [16:0]          PADDR,
  input  wire logic [31:0]          PWDATA,
  output logic      [31:0]          PRDATA,
  output logic                      PREADY,
  output logic                      PSLVERR,
  input  wire logic                 SETUP_VALID,
  input  wire logic                 SETUP_OK,
  input  wire logic [63:0]          SETUP_BYTES,
  output logic                      SETUP_ACK,
  input  wire logic                 TXN_VALID,
  input  wire usbebc_pkg::usbebc_txn_t TXN,
  output logic                      BUSY,
  output usbebc_pkg::usbebc_resp_t  RESP,
  output logic                      IRQ
);
  typedef enum logic [2:0] {S_IDLE, S_SU0, S_SU1, S_CFG, S_BUF, S_DEC} usbebc_state_t;
  localparam int ST_W_L = usbebc_pkg::ST_W;

  usbebc_state_t             state_ff;
  usbebc_pkg::usbebc_txn_t   txn_ff;
  logic                      txn_pend_ff;
  logic                      su_pend_ff;
  logic [63:0]               su_data_ff;
  logic [31:0]               cfg_ff;
  logic [31:0]               sel_ff;
  logic [usbebc_pkg::MC_W-1:0] main_ff;
  logic [usbebc_pkg::ST_W-1:0] stat_ff;
  logic [usbebc_pkg::ST_W-1:0] mask_ff;
  logic [1:0]                gate_ff;
  logic                      apb_ph_ff;
  logic                      apb_ram_ff;
  logic                      apb_bad_ff;
  logic [31:0]               apb_reg_ff;
  logic                      ram_we;
  logic [9:0]                ram_addr;
  logic [31:0]               ram_wdata;
  logic [31:0]               ram_q;
  logic                      apb_go;
  logic                      eng_go;
  logic                      in_ram;
  logic [ST_W_L-1:0]         st_set;
  logic [31:0]               cfg;
  logic [31:0]               nxt_bs;
  logic [15:0]               half;
  logic [15:0]               nh;
  logic                      sel;
  logic                      done;
  logic                      last_ev;
  logic                      err_ev;
  logic [11:0]               addr;
  usbebc_pkg::usbebc_code_t  code;

  // Word index of an endpoint control word inside a page of the low 256 bytes
  function automatic logic [9:0] ctl_word(input logic [4:0] page, input logic [3:0] ep,
                                          input logic dir_in);
    ctl_word = {page, ep, ~dir_in};
  endfunction

  assign in_ram = (PADDR[16:12] == usbebc_pkg::RAM_PAGE); // RQ1
  assign apb_go = PSEL & PENABLE & ~PREADY & ~apb_ph_ff & (state_ff == S_IDLE)
                  & ~su_pend_ff & ~txn_pend_ff;
  assign eng_go = (state_ff == S_IDLE) & ~apb_ph_ff & (su_pend_ff | txn_pend_ff);

  usbebc_ram #(.AW(usbebc_pkg::WAW), .DW(32)) u_ram (
    .clk      (CORE_CLK),
    .we       (ram_we),
    .addr     (ram_addr),
    .wdata    (ram_wdata),
    .rdata_ff (ram_q)
  );

  // Single RAM port: engine owns it outside idle, APB otherwise
  always_comb begin
    ram_we    = 1'b0;
    ram_addr  = PADDR[11:2];
    ram_wdata = PWDATA;
    case (state_ff)
      S_SU0: begin
        ram_we    = 1'b1; // RQ22
        ram_addr  = usbebc_pkg::SETUP_W0;
        ram_wdata = su_data_ff[31:0];
      end
      S_SU1: begin
        ram_we    = 1'b1; // RQ22
        ram_addr  = usbebc_pkg::SETUP_W1;
        ram_wdata = su_data_ff[63:32];
      end
      S_CFG: ram_addr = ctl_word(5'h00, txn_ff.ep, txn_ff.dir_in);
      S_BUF: ram_addr = ctl_word(usbebc_pkg::BS_PAGE, txn_ff.ep, txn_ff.dir_in);
      S_DEC: begin
        ram_we    = 1'b1;
        ram_addr  = ctl_word(usbebc_pkg::BS_PAGE, txn_ff.ep, txn_ff.dir_in);
        ram_wdata = nxt_bs;
      end
      default: ram_we = apb_go & PWRITE & in_ram;
    endcase
  end

  // Request capture
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      su_pend_ff  <= 1'b0;
      txn_pend_ff <= 1'b0;
      su_data_ff  <= 64'h0;
      txn_ff      <= '0;
    end else begin
      if (SETUP_VALID & SETUP_OK & ~su_pend_ff) begin
        su_pend_ff <= 1'b1; // RQ22
        su_data_ff <= SETUP_BYTES;
      end else if (state_ff == S_SU0) begin
        su_pend_ff <= 1'b0;
      end
      if (TXN_VALID & ~BUSY) begin
        txn_pend_ff <= 1'b1;
        txn_ff      <= TXN;
      end else if (eng_go & ~su_pend_ff) begin
        txn_pend_ff <= 1'b0;
      end
    end
  end

  // Engine sequence
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      state_ff <= S_IDLE;
    end else begin
      case (state_ff)
        S_IDLE: if (eng_go) state_ff <= su_pend_ff ? S_SU0 : S_CFG;
        S_SU0:  state_ff <= S_SU1;
        S_SU1:  state_ff <= S_IDLE;
        S_CFG:  state_ff <= S_BUF;
        S_BUF:  state_ff <= S_DEC;
        S_DEC:  state_ff <= S_IDLE;
        default: state_ff <= S_IDLE;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      cfg_ff <= 32'h0;
    end else if (state_ff == S_BUF) begin
      cfg_ff <= ram_q;
    end
  end

  // Transaction decision on the buffer state word read back
  always_comb begin
    cfg = cfg_ff;
    if (txn_ff.ep == 4'h0) begin
      cfg = 32'h0; // RQ2
      cfg[usbebc_pkg::CF_EN]     = 1'b1;
      cfg[usbebc_pkg::CF_DBL]    = main_ff[usbebc_pkg::MC_DBL];
      cfg[usbebc_pkg::CF_IBUF]   = main_ff[usbebc_pkg::MC_IBUF]; // RQ3
      cfg[usbebc_pkg::CF_I2]     = main_ff[usbebc_pkg::MC_I2];
      cfg[usbebc_pkg::CF_ISTALL] = main_ff[usbebc_pkg::MC_ISTALL];
      cfg[usbebc_pkg::CF_INAK]   = main_ff[usbebc_pkg::MC_INAK];
      cfg[15:6]                  = usbebc_pkg::EP0_BASE; // RQ2
    end
    sel = cfg[usbebc_pkg::CF_DBL] & sel_ff[{txn_ff.ep, ~txn_ff.dir_in}]; // RQ11
    if (~main_ff[usbebc_pkg::MC_HOST] & ram_q[usbebc_pkg::BS_RSTSEL]) begin
      sel = 1'b0; // RQ12
    end
    half = sel ? ram_q[31:16] : ram_q[15:0]; // RQ10
    addr = {cfg[11:6], 6'h00}; // RQ9
    if (sel) begin
      addr = addr + ((cfg[27:26] == usbebc_pkg::EPT_ISO) ?
             (usbebc_pkg::ISO_STEP << ram_q[28:27]) : usbebc_pkg::SB_STEP); // RQ17
    end
    nh      = half;
    nxt_bs  = ram_q;
    done    = 1'b0;
    err_ev  = 1'b0;
    code    = usbebc_pkg::RSP_NAK;
    if (~cfg[usbebc_pkg::CF_EN]) begin // RQ4
      code = usbebc_pkg::RSP_NAK;
    end else if (main_ff[usbebc_pkg::MC_HOST]) begin
      if (txn_ff.stalled) begin
        nxt_bs[usbebc_pkg::BS_STALL] = 1'b1; // RQ19
        code = usbebc_pkg::RSP_STALL;
      end else if (half[usbebc_pkg::BH_AVAIL] & ~half[usbebc_pkg::BH_FULL]) begin
        err_ev = ~txn_ff.ok;
        done   = txn_ff.ok | (cfg[27:26] == usbebc_pkg::EPT_ISO)
                 | (cfg[27:26] == usbebc_pkg::EPT_INTR); // RQ20
        code   = txn_ff.ok ? usbebc_pkg::RSP_ACK : usbebc_pkg::RSP_NONE;
        nh[usbebc_pkg::BH_FULL] = txn_ff.dir_in | ~txn_ff.ok; // RQ20
      end
    end else if (ram_q[usbebc_pkg::BS_STALL] &
                 ((txn_ff.ep != 4'h0) | gate_ff[~txn_ff.dir_in])) begin
      code = usbebc_pkg::RSP_STALL; // RQ19 RQ23
    end else if (txn_ff.dir_in & half[usbebc_pkg::BH_AVAIL] & half[usbebc_pkg::BH_FULL]) begin
      done = 1'b1;
      code = usbebc_pkg::RSP_DATA;
      nh[usbebc_pkg::BH_FULL] = 1'b0; // RQ13
    end else if (~txn_ff.dir_in & half[usbebc_pkg::BH_AVAIL] & ~half[usbebc_pkg::BH_FULL]) begin
      done = 1'b1;
      code = (cfg[27:26] == usbebc_pkg::EPT_ISO) ? usbebc_pkg::RSP_NONE : usbebc_pkg::RSP_ACK;
      nh[usbebc_pkg::BH_FULL] = 1'b1; // RQ13
      nh[9:0] = txn_ff.rx_len; // RQ18
      nh[usbebc_pkg::BH_PID]  = txn_ff.rx_pid; // RQ16
    end else if (cfg[27:26] == usbebc_pkg::EPT_ISO) begin // RQ6
      code = usbebc_pkg::RSP_NONE;
    end
    if (~txn_ff.dir_in & main_ff[usbebc_pkg::MC_HOST] & done) begin
      nh[9:0] = txn_ff.rx_len;
    end
    last_ev = done & half[usbebc_pkg::BH_LAST]; // RQ15
    if (done) begin
      nh[12:10] = 3'b000; // RQ14
      if (sel) begin
        nxt_bs[31:16] = {nh[15:13], ram_q[28:27], nh[10:0]}; // RQ17
      end else begin
        nxt_bs[15:0] = nh;
      end
      if (last_ev) begin
        nxt_bs[usbebc_pkg::BS_RSTSEL] = 1'b0; // RQ12
      end
    end
  end

  // Hidden buffer selector per endpoint and direction
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      sel_ff <= 32'h0;
    end else if (state_ff == S_DEC & cfg[usbebc_pkg::CF_DBL] & (done | ~sel)) begin
      sel_ff[{txn_ff.ep, ~txn_ff.dir_in}] <= done ? ~sel : sel; // RQ11 RQ12
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      RESP <= '0;
    end else begin
      RESP.valid <= (state_ff == S_DEC);
      if (state_ff == S_DEC) begin
        RESP.code <= code;
        RESP.addr <= addr;
        RESP.len  <= half[9:0];
        RESP.pid  <= half[usbebc_pkg::BH_PID];
        RESP.poll <= (main_ff[usbebc_pkg::MC_HOST] & (cfg[27:26] == usbebc_pkg::EPT_INTR)) ?
                     ({1'b0, cfg[25:18]} + usbebc_pkg::POLL_ADD) : 9'h000; // RQ7
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      SETUP_ACK <= 1'b0;
      BUSY      <= 1'b0;
    end else begin
      SETUP_ACK <= (state_ff == S_SU1); // RQ22
      BUSY      <= (TXN_VALID & ~BUSY) | txn_pend_ff | (state_ff != S_IDLE);
    end
  end

  // Status events; a set in the same cycle as a clear wins
  always_comb begin
    st_set = '0;
    st_set[usbebc_pkg::ST_SETUP] = (state_ff == S_SU1); // RQ24
    if (state_ff == S_DEC) begin
      st_set[usbebc_pkg::ST_BUF]   = done & (cfg[usbebc_pkg::CF_IBUF] |
                                     (cfg[usbebc_pkg::CF_I2] & cfg[usbebc_pkg::CF_DBL] & sel)); // RQ5
      st_set[usbebc_pkg::ST_STALL] = (code == usbebc_pkg::RSP_STALL) & cfg[usbebc_pkg::CF_ISTALL]; // RQ8
      st_set[usbebc_pkg::ST_NAK]   = (code == usbebc_pkg::RSP_NAK) & cfg[usbebc_pkg::CF_INAK]; // RQ8
      st_set[usbebc_pkg::ST_LAST]  = last_ev;
      st_set[usbebc_pkg::ST_ERR]   = err_ev; // RQ20
    end
  end

  // Software registers
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      main_ff <= usbebc_pkg::MAIN_RST;
      mask_ff <= usbebc_pkg::MASK_RST;
      stat_ff <= usbebc_pkg::STAT_RST;
      gate_ff <= 2'b00;
      IRQ     <= 1'b0;
    end else begin
      if (apb_go & PWRITE & (PADDR == usbebc_pkg::REG_MAIN)) main_ff <= PWDATA[usbebc_pkg::MC_W-1:0];
      if (apb_go & PWRITE & (PADDR == usbebc_pkg::REG_MASK)) mask_ff <= PWDATA[ST_W_L-1:0];
      if (state_ff == S_SU1) begin
        gate_ff <= 2'b00; // RQ23
      end else if (apb_go & PWRITE & (PADDR == usbebc_pkg::REG_GATE)) begin
        gate_ff <= PWDATA[1:0];
      end
      stat_ff <= (stat_ff & ~((apb_go & PWRITE & (PADDR == usbebc_pkg::REG_STAT)) ?
                 PWDATA[ST_W_L-1:0] : '0)) | st_set;
      IRQ     <= |(stat_ff & mask_ff); // RQ24
    end
  end

  // APB: issue, one wait for RAM read, then ready
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      apb_ph_ff  <= 1'b0;
      apb_ram_ff <= 1'b0;
      apb_bad_ff <= 1'b0;
      apb_reg_ff <= 32'h0;
      PREADY     <= 1'b0;
      PSLVERR    <= 1'b0;
      PRDATA     <= 32'h0;
    end else begin
      apb_ph_ff <= apb_go;
      PREADY    <= apb_ph_ff;
      if (apb_go) begin
        apb_ram_ff <= in_ram;
        apb_bad_ff <= 1'b0;
        case (PADDR)
          usbebc_pkg::REG_MAIN: apb_reg_ff <= {26'h0, main_ff};
          usbebc_pkg::REG_STAT: apb_reg_ff <= {26'h0, stat_ff};
          usbebc_pkg::REG_GATE: apb_reg_ff <= {30'h0, gate_ff};
          usbebc_pkg::REG_MASK: apb_reg_ff <= {26'h0, mask_ff};
          default: begin
            apb_reg_ff <= 32'h0;
            apb_bad_ff <= ~in_ram;
          end
        endcase
      end
      if (apb_ph_ff) begin
        PRDATA  <= apb_ram_ff ? ram_q : apb_reg_ff;
        PSLVERR <= apb_bad_ff;
      end else begin
        PSLVERR <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  a_apb_latency: assert property (apb_go |-> ##2 PREADY)
    else $error("APB answer not two cycles after issue");
  a_setup_ack_flag: assert property (SETUP_ACK |-> stat_ff[usbebc_pkg::ST_SETUP]) // RQ24
    else $error("Setup ack without received flag");
  a_setup_gate_clr: assert property (SETUP_ACK |-> gate_ff == 2'b00) // RQ23
    else $error("Stall gates not cleared by setup");
  a_setup_path: assert property (SETUP_VALID & SETUP_OK & ~su_pend_ff & ~txn_pend_ff
    & (state_ff == S_IDLE) & ~apb_ph_ff |-> ##[4:5] SETUP_ACK) // RQ22
    else $error("Setup not acknowledged in time");
  a_ep0_stall_gate: assert property (RESP.valid & (RESP.code == usbebc_pkg::RSP_STALL)
    & (txn_ff.ep == 4'h0) & ~main_ff[usbebc_pkg::MC_HOST] |-> gate_ff[~txn_ff.dir_in]) // RQ23
    else $error("Endpoint zero stalled without gate");
  a_ep0_base_addr: assert property (RESP.valid & (txn_ff.ep == 4'h0) & ~main_ff[usbebc_pkg::MC_DBL]
    |-> RESP.addr == usbebc_pkg::DATA_FIRST) // RQ2
    else $error("Endpoint zero buffer not at 0x100");
  a_in_clears_full: assert property ((state_ff == S_DEC) & (code == usbebc_pkg::RSP_DATA)
    |-> ~nh[usbebc_pkg::BH_FULL] & ~nh[usbebc_pkg::BH_AVAIL]) // RQ13 RQ14
    else $error("IN completion left full or available");
  a_base_aligned: assert property (RESP.valid |-> RESP.addr[5:0] == 6'h00) // RQ9
    else $error("Buffer address not 64-byte aligned");
  a_status_set_wins: assert property (st_set[usbebc_pkg::ST_SETUP] |=> stat_ff[usbebc_pkg::ST_SETUP])
    else $error("Status event lost"); // RQ24
  c_setup_done: cover property (SETUP_ACK);
  c_in_data: cover property (RESP.valid & (RESP.code == usbebc_pkg::RSP_DATA));
  c_stall_sent: cover property (RESP.valid & (RESP.code == usbebc_pkg::RSP_STALL));
  c_apb_write: cover property (PREADY & PWRITE);
endmodule

/* File: design/usbebc_pkg.sv */
package usbebc_pkg;
  // APB address space
  localparam int          PAW        = 17;
  localparam int          WAW        = 10;
  localparam logic [16:0] REG_MAIN   = 17'h10000;
  localparam logic [16:0] REG_STAT   = 17'h10004;
  localparam logic [16:0] REG_GATE   = 17'h10008;
  localparam logic [16:0] REG_MASK   = 17'h1000c;
  localparam logic [4:0]  RAM_PAGE   = 5'h00;
  localparam logic [11:0] DATA_FIRST = 12'h100;
  localparam logic [9:0]  SETUP_W0   = 10'h000;
  localparam logic [9:0]  SETUP_W1   = 10'h001;
  localparam logic [4:0]  BS_PAGE    = 5'h01;
  // Endpoint configuration word
  localparam int          CF_EN      = 31;
  localparam int          CF_DBL     = 30;
  localparam int          CF_IBUF    = 29;
  localparam int          CF_I2      = 28;
  localparam int          CF_TYP     = 26;
  localparam int          CF_POLL    = 18;
  localparam int          CF_ISTALL  = 17;
  localparam int          CF_INAK    = 16;
  localparam int          CF_BASE    = 6;
  localparam logic [9:0]  EP0_BASE   = 10'h004;
  // Buffer state word, per half
  localparam int          HALF       = 16;
  localparam int          BH_FULL    = 15;
  localparam int          BH_LAST    = 14;
  localparam int          BH_PID     = 13;
  localparam int          BH_AVAIL   = 10;
  localparam int          BS_RSTSEL  = 12;
  localparam int          BS_STALL   = 11;
  localparam int          BS_ISO     = 27;
  localparam logic [11:0] SB_STEP    = 12'h040;
  localparam logic [11:0] ISO_STEP   = 12'h080;
  localparam logic [8:0]  POLL_ADD   = 9'h001;
  // Main control and status bits
  localparam int          MC_W       = 6;
  localparam int          MC_HOST    = 0;
  localparam int          MC_IBUF    = 1;
  localparam int          MC_I2      = 2;
  localparam int          MC_ISTALL  = 3;
  localparam int          MC_INAK    = 4;
  localparam int          MC_DBL     = 5;
  localparam int          ST_W       = 6;
  localparam int          ST_SETUP   = 0;
  localparam int          ST_BUF     = 1;
  localparam int          ST_STALL   = 2;
  localparam int          ST_NAK     = 3;
  localparam int          ST_LAST    = 4;
  localparam int          ST_ERR     = 5;
  localparam logic [MC_W-1:0] MAIN_RST = 6'h00;
  localparam logic [ST_W-1:0] STAT_RST = 6'h00;
  localparam logic [ST_W-1:0] MASK_RST = 6'h00;

  typedef enum logic [1:0] {EPT_CTRL, EPT_ISO, EPT_BULK, EPT_INTR} usbebc_eptype_t;
  typedef enum logic [2:0] {RSP_NONE, RSP_ACK, RSP_NAK, RSP_STALL, RSP_DATA} usbebc_code_t;

  typedef struct packed {
    logic [3:0] ep;
    logic       dir_in;
    logic [9:0] rx_len;
    logic       rx_pid;
    logic       ok;
    logic       stalled;
  } usbebc_txn_t;

  typedef struct packed {
    logic         valid;
    usbebc_code_t code;
    logic [11:0]  addr;
    logic [9:0]   len;
    logic         pid;
    logic [8:0]   poll;
  } usbebc_resp_t;
endpackage

/* File: design/usbebc_ram.sv */
`timescale 1ns/100ps
module usbebc_ram #(
  parameter int AW = 10,
  parameter int DW = 32
) (
  input  wire logic          clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  output logic      [DW-1:0] rdata_ff
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata_ff <= mem[addr];
  end
endmodule

/* File: tb/usbebc_host_model.sv */
`timescale 1ns/100ps
module usbebc_host_model (
  input  wire logic                     clk,
  output logic                          setup_valid,
  output logic                          setup_ok,
  output logic [63:0]                   setup_bytes,
  input  wire logic                     setup_ack,
  output logic                          txn_valid,
  output usbebc_pkg::usbebc_txn_t       txn,
  input  wire logic                     busy,
  input  wire usbebc_pkg::usbebc_resp_t resp
);
  initial begin
    setup_valid = 1'b0;
    setup_ok    = 1'b0;
    setup_bytes = 64'h0;
    txn_valid   = 1'b0;
    txn         = '0;
  end

  // Released lines show the inverse of the last value
  task automatic send_setup(input logic [63:0] b, input logic ok, input int gap,
                            output logic acked);
    acked = 1'b0;
    repeat (gap + 1) @(posedge clk);
    setup_valid <= 1'b1;
    setup_ok    <= ok;
    setup_bytes <= b;
    @(posedge clk);
    setup_valid <= 1'b0;
    setup_ok    <= ~ok;
    setup_bytes <= ~b;
    repeat (10) begin
      @(posedge clk);
      if (setup_ack === 1'b1) acked = 1'b1;
    end
  endtask

  task automatic send_txn(input usbebc_pkg::usbebc_txn_t t,
                          output usbebc_pkg::usbebc_resp_t r);
    int n;
    n = 0;
    @(posedge clk);
    while (busy !== 1'b0) @(posedge clk);
    txn_valid <= 1'b1;
    txn       <= t;
    @(posedge clk);
    txn_valid <= 1'b0;
    txn       <= ~t;
    while (resp.valid !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    r = resp;
  endtask
endmodule

/* File: tb/tb_usb_endpoint_buffer_control.sv */
`timescale 1ns/100ps
module tb_usb_endpoint_buffer_control;
  logic                     clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [16:0]              paddr;
  logic [31:0]              pwdata, prdata, rdata;
  logic                     setup_valid, setup_ok, setup_ack, txn_valid, busy, irq;
  logic                     rerr, acked;
  logic [63:0]              setup_bytes;
  usbebc_pkg::usbebc_txn_t  txn;
  usbebc_pkg::usbebc_resp_t resp, rsp;
  int                       failures = 0, comparisons = 0, cycles = 0;

  usbebc_top i_usbebc_top (.CORE_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .SETUP_VALID(setup_valid), .SETUP_OK(setup_ok),
    .SETUP_BYTES(setup_bytes), .SETUP_ACK(setup_ack), .TXN_VALID(txn_valid), .TXN(txn),
    .BUSY(busy), .RESP(resp), .IRQ(irq));

  usbebc_host_model i_usbebc_host_model (.clk(clk), .setup_valid(setup_valid),
    .setup_ok(setup_ok), .setup_bytes(setup_bytes), .setup_ack(setup_ack),
    .txn_valid(txn_valid), .txn(txn), .busy(busy), .resp(resp));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      wrap_up();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [16:0] a, input logic [31:0] d);
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rdata = prdata;
    rerr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [16:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [16:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdata, exp);
  endtask

  task automatic go(input logic [3:0] e, input logic din, input logic ok);
    usbebc_pkg::usbebc_txn_t t;
    t = '{ep: e, dir_in: din, rx_len: 10'h005, rx_pid: 1'b0, ok: ok, stalled: 1'b0};
    i_usbebc_host_model.send_txn(t, rsp);
  endtask

  task automatic cc(input usbebc_pkg::usbebc_code_t c);
    chk({29'h0, rsp.code}, {29'h0, c});
  endtask

  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 17'h0;
    pwdata = 32'h0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rdc(usbebc_pkg::REG_MAIN, 32'h0);
    rdc(usbebc_pkg::REG_MASK, 32'h0);
    wr(17'h00ffc, 32'h5a5aa5a5);
    rdc(17'h00ffc, 32'h5a5aa5a5);
    wr(17'h01000, 32'h1);
    chk({31'h0, rerr}, 32'h1);
    rdc(17'h01000, 32'h0);
    // Setup capture, gate clearing and status flag
    wr(usbebc_pkg::REG_GATE, 32'h3);
    i_usbebc_host_model.send_setup(64'h0706050403020100, 1'b1, 0, acked);
    chk({31'h0, acked}, 32'h1);
    rdc(17'h00000, 32'h03020100);
    rdc(17'h00004, 32'h07060504);
    rdc(usbebc_pkg::REG_GATE, 32'h0);
    rdc(usbebc_pkg::REG_STAT, 32'h1);
    chk({31'h0, irq}, 32'h0);
    wr(usbebc_pkg::REG_MASK, 32'h1);
    @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    wr(usbebc_pkg::REG_STAT, 32'h1);
    rdc(usbebc_pkg::REG_STAT, 32'h0);
    i_usbebc_host_model.send_setup(64'hffeeddccbbaa9988, 1'b0, 2, acked);
    chk({31'h0, acked}, 32'h0);
    rdc(17'h00000, 32'h03020100);
    // Endpoint zero stall gating and data
    wr(17'h00080, 32'h00000800);
    go(4'h0, 1'b1, 1'b1);
    cc(usbebc_pkg::RSP_NAK);
    wr(usbebc_pkg::REG_GATE, 32'h1);
    go(4'h0, 1'b1, 1'b1);
    cc(usbebc_pkg::RSP_STALL);
    wr(usbebc_pkg::REG_GATE, 32'h0);
    wr(17'h00080, 32'h0000a408);
    go(4'h0, 1'b1, 1'b1);
    cc(usbebc_pkg::RSP_DATA);
    chk({20'h0, rsp.addr}, {20'h0, usbebc_pkg::DATA_FIRST});
    chk({21'h0, rsp.pid, rsp.len}, 32'h00000408);
    rdc(17'h00080, 32'h00002008);
    // Double buffered IN, base with low bits set
    wr(17'h00008, 32'hc800023f);
    wr(17'h00088, 32'h8420a410);
    go(4'h1, 1'b1, 1'b1);
    chk({20'h0, rsp.addr}, 32'h00000200);
    chk({21'h0, rsp.pid, rsp.len}, 32'h00000410);
    go(4'h1, 1'b1, 1'b1);
    chk({20'h0, rsp.addr}, 32'h00000240);
    chk({21'h0, rsp.pid, rsp.len}, 32'h00000020);
    rdc(17'h00088, 32'h00202010);
    go(4'h1, 1'b1, 1'b1);
    cc(usbebc_pkg::RSP_NAK);
    wr(17'h00088, 32'h0000a410);
    go(4'h1, 1'b1, 1'b1);
    wr(17'h00088, 32'h8420b410);
    go(4'h1, 1'b1, 1'b1);
    chk({20'h0, rsp.addr}, 32'h00000200);
    // Every transfer type with nothing available, then disabled
    wr(17'h00090, 32'h0);
    for (int k = 0; k < 4; k++) begin
      wr(17'h00010, 32'h80000000 | (32'(k) << 26));
      go(4'h2, 1'b1, 1'b1);
      cc(k == 1 ? usbebc_pkg::RSP_NONE : usbebc_pkg::RSP_NAK);
    end
    wr(17'h00090, 32'h0000a410);
    wr(17'h00010, 32'h08000000);
    go(4'h2, 1'b1, 1'b1);
    cc(usbebc_pkg::RSP_NAK);
    // Single buffered OUT
    wr(17'h0000c, 32'h88000280);
    wr(17'h0008c, 32'h00000400);
    go(4'h1, 1'b0, 1'b1);
    cc(usbebc_pkg::RSP_ACK);
    chk({20'h0, rsp.addr}, 32'h00000280);
    apb(1'b0, 17'h0008c, 32'h0);
    chk(rdata & 32'hffff8400, 32'h00008000);
    // Isochronous double buffered IN, armed after the other fields
    wr(17'h00020, 32'he4020400);
    wr(17'h000a0, 32'h9011c022);
    wr(17'h000a0, 32'h9411c422);
    go(4'h4, 1'b1, 1'b1);
    chk({20'h0, rsp.addr}, 32'h00000400);
    go(4'h4, 1'b1, 1'b1);
    chk({20'h0, rsp.addr}, 32'h00000600);
    rdc(usbebc_pkg::REG_STAT, 32'h00000012);
    wr(17'h000a0, 32'h00000800);
    go(4'h4, 1'b1, 1'b1);
    cc(usbebc_pkg::RSP_STALL);
    rdc(usbebc_pkg::REG_STAT, 32'h00000016);
    // Host interrupt endpoint, failed transfer
    wr(usbebc_pkg::REG_MAIN, 32'h1);
    wr(17'h0001c, 32'h8c240300);
    wr(17'h0009c, 32'h00000404);
    go(4'h3, 1'b0, 1'b0);
    chk({23'h0, rsp.poll}, 32'h0000000a);
    apb(1'b0, 17'h0009c, 32'h0);
    chk(rdata & 32'h00008000, 32'h00008000);
    apb(1'b0, usbebc_pkg::REG_STAT, 32'h0);
    chk(rdata & 32'h00000020, 32'h00000020);
    wrap_up();
  end
endmodule
